// [logic/crc_lock_status_logic.v]
`timescale 1ns/100ps
// Summary of operation
// - Sample checksum recomputed every output cycle
// - Bytes lowest first, bits MSB first
// - 72 bits: current, voltage one, voltage two
// - Seed all ones, polynomial taps 0,5,12
// - Feedback input xor top bit, shift
// - Sample checksum readable by register read
// - Config bit 3 selects temperature input
// - Single-voltage variant always measures temperature
// - Temperature valid 5 ms after select
// - Read-only signed sensor offset register
// - Locked: config writes refused, reads free
// - 0xCA locks, 0x9C unlocks
// - Internal registers unwritable, keep defaults
// - Config checksum over 64-bit state array
// - Same algorithm, 64 steps, stored
// - Config checksum change sets status bit
// - Lock sets status bit, reasserted each output cycle while locked
// - Reset-on bit clears after reset ends
// - Unread samples set missed flag, read clears
// - Both status registers readable
// - Status two low bits give version
// - Rate field divides clock 512 to 4096
`include "crc_lock_defs.vh"
module crc_lock_status_logic #(
  parameter HAS_V2 = 1,
  parameter [7:0] SENSOR_OFFSET = 8'h00,
  // Arbitrary value
  parameter [2:0] VERSION = 3'h1,
  parameter SETTLE_CYC =
    `TEMP_SETTLE_MS * (`NS_PER_MS / `MCLK_PERIOD_NS)
) (
  input wire mclk,
  input wire reset_n,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [23:0] current_in,
  input wire [23:0] voltage_one_in,
  input wire [23:0] voltage_two_in,
  input wire [23:0] temp_sensor_in,
  output reg [23:0] reg_rdata_q,
  output reg temp_select_q,
  output reg temp_settled_q,
  output reg output_cycle_q,
  output reg write_locked_q
);

  reg [12:0] div_q;
  reg [7:0] config_q;
  reg [7:0] emission_control_q;
  reg [23:0] current_sample_q;
  reg [23:0] voltage_one_sample_q;
  reg [23:0] voltage_two_sample_q;
  reg [15:0] sample_checksum_q;
  reg [15:0] settings_checksum_q;
  reg [15:0] scrc_q;
  reg [15:0] ccrc_q;
  reg [71:0] sstream_q;
  reg [63:0] cstream_q;
  reg [6:0] step_q;
  reg busy_q;
  reg ccrc_valid_q;
  reg reset_on_q;
  reg crc_stat_q;
  reg prot_flag_q;
  reg missed_q;
  reg [2:0] seen_q;
  reg [19:0] settle_q;

  wire [1:0] output_rate_sel = config_q[`CFG_RATE_HI:`CFG_RATE_LO];
  wire [12:0] period = `BASE_DIV << output_rate_sel;
  wire tick = (div_q == period - 13'd1);
  wire wr_ok = reg_wr && !write_locked_q;
  wire rd_s0 = reg_rd && (reg_addr == `A_STAT0);
  wire rd_s1 = reg_rd && (reg_addr == `A_STAT1);
  wire [7:0] status_first = {5'd0, prot_flag_q, crc_stat_q, reset_on_q};
  wire [7:0] status_second = {4'd0, missed_q, VERSION};
  wire temp_path = temp_select_q || (HAS_V2 == 0);
  wire [63:0] cfg_array = {write_locked_q, status_second[`S1_BIT7],
    6'd0, `INT_RST, `INT_RST, `INT_RST, `INT_RST,
    SENSOR_OFFSET, emission_control_q, config_q};

  // lowest byte first, MSB of each byte first
  wire [6:0] bit_idx = {step_q[6:3], ~step_q[2:0]};
  wire s_in = sstream_q[bit_idx];
  wire c_in = cstream_q[bit_idx[5:0]];
  wire s_fb = s_in ^ scrc_q[15];
  wire c_fb = c_in ^ ccrc_q[15];
  wire [15:0] crc_poly = `CRC_POLY;
  wire [15:0] scrc_d;
  wire [15:0] ccrc_d;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_lfsr
      if (gi == 0) begin : g_low
        assign scrc_d[gi] = s_fb & crc_poly[gi];
        assign ccrc_d[gi] = c_fb & crc_poly[gi];
      end else begin : g_up
        assign scrc_d[gi] = scrc_q[gi - 1] ^ (s_fb & crc_poly[gi]);
        assign ccrc_d[gi] = ccrc_q[gi - 1] ^ (c_fb & crc_poly[gi]);
      end
    end
  endgenerate

  // Last step indices of the two serial runs
  localparam [6:0] SMP_LAST = `SMP_BITS - 7'd1;
  localparam [6:0] CFG_LAST = `CFG_BITS - 7'd1;

  // Unmapped and write-only addresses read zero
  reg [23:0] rdata_d;
  always @* begin
    case (reg_addr)
      `A_CUR: rdata_d = current_sample_q;
      `A_V1: rdata_d = voltage_one_sample_q;
      `A_V2: rdata_d = voltage_two_sample_q;
      `A_SCRC: rdata_d = {8'd0, sample_checksum_q};
      `A_CCRC: rdata_d = {8'd0, settings_checksum_q};
      `A_CONFIG: rdata_d = {16'd0, config_q};
      `A_STAT0: rdata_d = {16'd0, status_first};
      `A_EMI: rdata_d = {16'd0, emission_control_q};
      `A_STAT1: rdata_d = {16'd0, status_second};
      `A_TOFS: rdata_d = {16'd0, SENSOR_OFFSET};
      default: rdata_d = 24'd0;
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n)
      reg_rdata_q <= 24'd0;
    else if (reg_rd)
      reg_rdata_q <= rdata_d;
  end

  always @(posedge mclk) begin
    if (!reset_n)
      div_q <= 13'd0;
    else
      div_q <= tick ? 13'd0 : div_q + 13'd1;
  end

  // Registered so the pulse leaves from a flip-flop
  always @(posedge mclk) begin
    if (!reset_n)
      output_cycle_q <= 1'b0;
    else
      output_cycle_q <= tick;
  end

  // writes refused while locked; internal never
  always @(posedge mclk) begin
    if (!reset_n)
      config_q <= `CONFIG_RST;
    else if (wr_ok && reg_addr == `A_CONFIG)
      config_q <= reg_wdata;
  end

  // Emission control shares the same lock
  always @(posedge mclk) begin
    if (!reset_n)
      emission_control_q <= `EMI_RST;
    else if (wr_ok && reg_addr == `A_EMI)
      emission_control_q <= reg_wdata;
  end

  // lock keys; lock register always open
  always @(posedge mclk) begin
    if (!reset_n)
      write_locked_q <= 1'b0;
    else if (reg_wr && reg_addr == `A_LOCK) begin
      if (reg_wdata == `KEY_LOCK)
        write_locked_q <= 1'b1;
      else if (reg_wdata == `KEY_UNLOCK)
        write_locked_q <= 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n)
      temp_select_q <= 1'b0;
    else
      temp_select_q <= config_q[`CFG_TEMP];
  end

  // settle counter restarts each time the temperature path turns on
  always @(posedge mclk) begin
    if (!reset_n) begin
      settle_q <= 20'd0;
      temp_settled_q <= 1'b0;
    end else if (!temp_path) begin
      settle_q <= 20'd0;
      temp_settled_q <= 1'b0;
    end else if (settle_q != SETTLE_CYC[19:0]) begin
      settle_q <= settle_q + 20'd1;
      temp_settled_q <= 1'b0;
    end else begin
      temp_settled_q <= 1'b1;
    end
  end

  // result always lands in voltage two slot
  always @(posedge mclk) begin
    if (!reset_n) begin
      current_sample_q <= 24'd0;
      voltage_one_sample_q <= 24'd0;
      voltage_two_sample_q <= 24'd0;
    end else if (tick) begin
      current_sample_q <= current_in;
      voltage_one_sample_q <= voltage_one_in;
      voltage_two_sample_q <= temp_path ? temp_sensor_in
                                        : voltage_two_in;
    end
  end

  // start both checksums each output cycle
  always @(posedge mclk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      step_q <= 7'd0;
      sstream_q <= 72'd0;
      cstream_q <= 64'd0;
    end else if (tick) begin
      busy_q <= 1'b1;
      step_q <= 7'd0;
      sstream_q <= {temp_path ? temp_sensor_in : voltage_two_in,
                    voltage_one_in, current_in};
      cstream_q <= cfg_array;
    end else if (busy_q) begin
      step_q <= step_q + 7'd1;
      if (step_q == SMP_LAST)
        busy_q <= 1'b0;
    end
  end

  // sample checksum, final state after 72 steps
  always @(posedge mclk) begin
    if (!reset_n) begin
      scrc_q <= `CRC_SEED;
      sample_checksum_q <= `CRC_SEED;
    end else if (tick) begin
      scrc_q <= `CRC_SEED;
    end else if (busy_q) begin
      scrc_q <= scrc_d;
      if (step_q == SMP_LAST)
        sample_checksum_q <= scrc_d;
    end
  end

  // settings checksum stops at 64 steps
  always @(posedge mclk) begin
    if (!reset_n) begin
      ccrc_q <= `CRC_SEED;
      settings_checksum_q <= `CRC_SEED;
      ccrc_valid_q <= 1'b0;
    end else if (tick) begin
      ccrc_q <= `CRC_SEED;
    end else if (busy_q && step_q < `CFG_BITS) begin
      ccrc_q <= ccrc_d;
      if (step_q == CFG_LAST) begin
        settings_checksum_q <= ccrc_d;
        ccrc_valid_q <= 1'b1;
      end
    end
  end

  // reset-on drops once reset ends
  // One low edge is enough to re-arm it
  always @(posedge mclk) begin
    if (!reset_n)
      reset_on_q <= 1'b1;
    else
      reset_on_q <= 1'b0;
  end

  // change flag; set beats the read clear
  wire crc_changed = busy_q && !tick && step_q == CFG_LAST &&
    ccrc_valid_q && ccrc_d != settings_checksum_q;
  always @(posedge mclk) begin
    if (!reset_n)
      crc_stat_q <= 1'b0;
    else if (crc_changed)
      crc_stat_q <= 1'b1;
    else if (rd_s0)
      crc_stat_q <= 1'b0;
  end

  // protection flag re-armed each output cycle while locked
  wire lock_set = reg_wr && reg_addr == `A_LOCK &&
    reg_wdata == `KEY_LOCK;
  always @(posedge mclk) begin
    if (!reset_n)
      prot_flag_q <= 1'b0;
    else if (lock_set || (tick && write_locked_q))
      prot_flag_q <= 1'b1;
    // Unlock drops the flag one clock after the lock bit clears
    else if (rd_s0 || !write_locked_q)
      prot_flag_q <= 1'b0;
  end

  // all three samples must be read per cycle
  // Starts full so the first tick raises nothing
  wire [2:0] rd_mask;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_seen
      assign rd_mask[ch] = reg_rd && (reg_addr == ch);
      always @(posedge mclk) begin
        if (!reset_n)
          seen_q[ch] <= 1'b1;
        else if (tick)
          seen_q[ch] <= 1'b0;
        else if (rd_mask[ch])
          seen_q[ch] <= 1'b1;
      end
    end
  endgenerate

  // A read in the tick cycle still sees the old sample
  always @(posedge mclk) begin
    if (!reset_n)
      missed_q <= 1'b0;
    else if (tick && (seen_q | rd_mask) != 3'b111)
      missed_q <= 1'b1;
    else if (rd_s1)
      missed_q <= 1'b0;
  end

endmodule

// [logic/crc_lock_defs.vh]
`ifndef CRC_LOCK_DEFS_VH
`define CRC_LOCK_DEFS_VH
// Register addresses
`define A_CUR 5'h00
`define A_V1 5'h01
`define A_V2 5'h02
`define A_RSV3 5'h03
`define A_SCRC 5'h04
`define A_CCRC 5'h05
`define A_CONFIG 5'h08
`define A_STAT0 5'h09
`define A_LOCK 5'h0A
`define A_EMI 5'h0E
`define A_STAT1 5'h0F
`define A_INT0 5'h10
`define A_INT1 5'h11
`define A_INT2 5'h12
`define A_INT3 5'h13
`define A_TOFS 5'h18
// Configuration fields
`define CFG_RATE_HI 5
`define CFG_RATE_LO 4
`define CFG_TEMP 3
`define CONFIG_RST 8'h00
`define EMI_RST 8'hFF
`define INT_RST 8'h00
// Status fields
`define S0_RESET_ON 0
`define S0_CRC_STAT 1
`define S0_PROT 2
`define S1_MISSED 3
`define S1_BIT7 7
// Lock codes
`define KEY_LOCK 8'hCA
`define KEY_UNLOCK 8'h9C
// Checksum
`define CRC_SEED 16'hFFFF
`define CRC_POLY 16'h1021
`define SMP_BITS 7'd72
`define CFG_BITS 7'd64
// Output cycle base divider (512 clocks at rate 00)
`define BASE_DIV 13'd512
// Timing
`define MCLK_PERIOD_NS 8
`define TEMP_SETTLE_MS 5
`define NS_PER_MS 1000000
`endif

// [dv/crc_lock_sva.sv]
`timescale 1ns/100ps
module crc_lock_sva (
  input wire mclk,
  input wire reset_n,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [23:0] reg_rdata_q,
  input wire temp_select_q,
  input wire temp_settled_q,
  input wire output_cycle_q,
  input wire write_locked_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire key_wr = reg_wr && reg_addr == 5'h0A;
  reg [13:0] gap_q;
  // Rate change may stretch one period, hence the wide upper bound
  always @(posedge mclk) begin
    if (!reset_n || output_cycle_q)
      gap_q <= 14'h0000;
    else
      gap_q <= gap_q + 14'h0001;
  end
  chk_lock_code: assert property (
    key_wr && reg_wdata == 8'hCA |=> write_locked_q)
    else $error("lock code left protection off");
  chk_unlock_code: assert property (
    key_wr && reg_wdata == 8'h9C |=> !write_locked_q)
    else $error("unlock code left protection on");
  chk_lock_keep: assert property (
    !key_wr || reg_wdata != 8'hCA && reg_wdata != 8'h9C
    |=> $stable(write_locked_q))
    else $error("protection changed without a key");
  chk_fixed_zero: assert property (
    reg_rd && (reg_addr == 5'h03 || reg_addr[4:2] == 3'b100)
    |=> reg_rdata_q == 24'h00_0000)
    else $error("fixed location read nonzero");
  chk_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  chk_tick_gap: assert property (
    output_cycle_q |-> gap_q >= 14'h01FF && gap_q <= 14'h1FFF)
    else $error("output cycle spacing out of range");
  chk_settle_early: assert property (
    $rose(temp_select_q) |=> !temp_settled_q [*8])
    else $error("temperature settled too early");
  chk_settle_path: assert property (
    $rose(temp_settled_q) |-> $past(temp_select_q, 8))
    else $error("settled without temperature path");
endmodule
bind crc_lock_status_logic crc_lock_sva i_crc_lock_sva (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .temp_select_q(temp_select_q),
  .temp_settled_q(temp_settled_q), .output_cycle_q(output_cycle_q),
  .write_locked_q(write_locked_q));

// [dv/host_model.sv]
`timescale 1ns/100ps
module host_model (
  input wire mclk,
  output reg [4:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata,
  output reg reg_rd
);
  initial begin
    reg_addr = 5'h1F;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Released data is inverted so stale values never look valid
  task access(input w, input [4:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = ~d;
    end
  endtask
endmodule

// [dv/crc_lock_status_logic_bench.sv]
`timescale 1ns/100ps
module crc_lock_status_logic_bench;
  localparam [7:0] OFS = 8'hA5;
  // Arbitrary value
  localparam [2:0] VER = 3'h5;
  reg mclk, reset_n, seen;
  reg [23:0] cur, v1, v2, tmp;
  reg [31:0] rnd;
  reg [23:0] exp_q[$];
  integer num_errors, tests_run, n;
  wire [4:0] addr;
  wire [7:0] wd;
  wire wr, rd, tsel, tset, tick, lock;
  wire [23:0] rdata;
  crc_lock_status_logic #(.SENSOR_OFFSET(OFS), .VERSION(VER),
    .SETTLE_CYC(20)) i_crc_lock_status_logic (.mclk(mclk),
    .reset_n(reset_n), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
    .reg_rd(rd), .current_in(cur), .voltage_one_in(v1),
    .voltage_two_in(v2), .temp_sensor_in(tmp), .reg_rdata_q(rdata),
    .temp_select_q(tsel), .temp_settled_q(tset),
    .output_cycle_q(tick), .write_locked_q(lock));
  host_model i_host_model (.mclk(mclk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wd), .reg_rd(rd));
  function [15:0] crc(input [71:0] a, input integer nb);
    integer i;
    reg fb;
    begin
      crc = 16'hFFFF;
      for (i = 0; i < nb; i = i + 1) begin
        fb = a[(i / 8) * 8 + 7 - i % 8] ^ crc[15];
        crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
    end
  endfunction
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input [23:0] got, input [23:0] e);
    begin
      tests_run = tests_run + 1;
      if (got !== e) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, e);
      end
    end
  endtask
  task chk(input [4:0] a, input [23:0] e);
    begin
      exp_q.push_back(e);
      i_host_model.access(1'b0, a, 8'h00);
    end
  endtask
  task wr8(input [4:0] a, input [7:0] d);
    i_host_model.access(1'b1, a, d);
  endtask
  task wait_tick(input integer extra);
    begin
      n = 0;
      @(posedge mclk);
      #1;
      while (tick !== 1'b1 && n < 9000) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      if (n >= 9000)
        cmp(24'h00_0000, 24'h00_0001);
      repeat (extra) @(posedge mclk);
      #1;
    end
  endtask
  task results;
    begin
      $display("checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Read data lands one edge after the strobe
  always @(negedge mclk) begin
    if (seen && exp_q.size() != 0)
      cmp(rdata, exp_q.pop_front());
    seen = rd;
  end
  // Four output cycles fit well inside this span
  initial begin
    #200000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    reset_n = 1'b0;
    seen = 1'b0;
    num_errors = 0;
    tests_run = 0;
    rnd = 32'h0c79_0f98;
    cur = lfsr(rnd);
    v1 = lfsr(cur);
    v2 = lfsr(v1);
    tmp = lfsr(v2);
    repeat (4) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk(5'h09, 24'h00_0000);
    chk(5'h18, {16'h0000, OFS});
    chk(5'h0F, {21'h00_0000, VER});
    wr8(5'h10, 8'h55);
    chk(5'h10, 24'h00_0000);
    wr8(5'h08, 8'h08);
    wr8(5'h0A, 8'hCA);
    cmp({23'h00_0000, lock}, 24'h00_0001);
    wr8(5'h08, 8'h30);
    wr8(5'h0E, 8'h00);
    wr8(5'h0A, 8'h11);
    chk(5'h08, 24'h00_0008);
    chk(5'h0E, 24'h00_00FF);
    cmp({23'h00_0000, tsel}, 24'h00_0001);
    chk(5'h09, 24'h00_0004);
    chk(5'h09, 24'h00_0000);
    $display("test lock done");
    wait_tick(80);
    cmp({23'h00_0000, tset}, 24'h00_0001);
    chk(5'h04, {8'h00, crc({tmp, v1, cur}, 72)});
    chk(5'h02, tmp);
    chk(5'h05, {8'h00, crc({16'h0080, 32'h0, OFS, 16'hFF08}, 64)});
    chk(5'h09, 24'h00_0004);
    wait_tick(80);
    chk(5'h0F, {20'h0_0000, 1'b1, VER});
    chk(5'h0F, {21'h00_0000, VER});
    $display("test checksum done");
    wr8(5'h0A, 8'h9C);
    cmp({23'h00_0000, lock}, 24'h00_0000);
    wr8(5'h08, 8'h10);
    chk(5'h08, 24'h00_0010);
    wait_tick(0);
    wait_tick(80);
    cmp(n[23:0], 24'h00_03FF);
    chk(5'h09, 24'h00_0002);
    chk(5'h02, v2);
    cmp({22'h00_0000, tsel, tset}, 24'h00_0000);
    repeat (2) @(posedge mclk);
    $display("test rate done");
    results;
  end
endmodule
